// ===== vrcr_regs.sv
// Bus-interface control and status register bank
// Summary of operation
// - Twelve-bit monitor level register, voltage mode
// - Read-only board info: memory size, type
// - Three-bit code selects analog monitor function
// - Report word count of next event
// - Control bit 7 selects interrupt release mode
// - Optical link interrupts always release on access
// - Writing level zero drops pending request
// - Acknowledge drops bus request when bit 7 is set; nonzero level re-arms
// - Control bit 6 selects base address source
// - Control bit 5 enables 64-bit alignment
// - Bit 3 optical interrupt; bits 2:0 level
// - Bus error flag, cleared by status read
// - Status shows buffer full and event ready
// - Slot ID from backplane or writable register
// - Two-bit daisy-chain role field
// - Eight-bit multicast address high bits
// - Relocation supplies base address bits 31:16
// - Drive status/ID value during acknowledge
// - Interrupt when stored events exceed threshold
// - Eight-bit events per block transfer
// - Writes pulse memory clear or software reset
`timescale 1ns/100ps
module vrcr_regs #(
  parameter bit         EXT_BACKPLANE = 1'b0,
  // Arbitrary neutral value
  parameter logic [7:0] BOARD_TYPE    = 8'h00,
  parameter logic [7:0] MEM_MBYTES    = 8'h01
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  input  wire logic        intAck,
  input  wire logic [2:0]  intAckLevel,
  output logic      [31:0] intAckData,
  output logic      [2:0]  vmeIrqLevel,
  output logic             vmeIrq,
  output logic             opticalIrq,
  input  wire logic [31:0] nextEventWords,
  input  wire logic [9:0]  storedEvents,
  input  wire logic        bufferFull,
  input  wire logic        eventReady,
  input  wire logic        busErrorEvent,
  input  wire logic [4:0]  backplaneSlot,
  input  wire logic [15:0] rotaryBase,
  output logic      [15:0] baseAddrHigh,
  output logic             alignEnable,
  output logic             busErrorEnable,
  output logic      [11:0] monitorLevel,
  output logic      [2:0]  monitorFunction,
  output logic      [4:0]  headerBoardId,
  output logic      [1:0]  chainRole,
  output logic      [7:0]  multicastHigh,
  output logic      [7:0]  bltEvents,
  output logic             memoryClear,
  output logic             softReset
);

  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl_r;
  logic [11:0] monDac_r;
  logic [2:0]  monFunc_r;
  logic [4:0]  slotId_r;
  logic [9:0]  mcast_r;
  logic [15:0] base_relocation_enable_r;
  logic [31:0] vector_r;
  logic [9:0]  thresh_r;
  logic [7:0]  blt_r;
  logic [31:0] scratch_r;
  logic        berrFlag_r;
  logic        vmeArmed_r;
  logic        vmePend_r;
  logic        optPend_r;
  logic [4:0]  slotSync1_r;
  logic [4:0]  slotSync2_r;
  logic [15:0] rotSync1_r;
  logic [15:0] rotSync2_r;
  logic [31:0] rdata_nxt;
  logic        wrCtrl;
  logic        overThresh;
  logic [2:0]  levelNxt;
  logic [4:0]  slotSrc;

  assign wrCtrl    = regWrite && (regAddr == vrcr_pkg::OFS_CTRL);
  assign levelNxt  = regWdata[2:0];
  assign overThresh = storedEvents > thresh_r;
  // slot source, backplane pins arrive two flops late
  assign slotSrc    = EXT_BACKPLANE ? slotSync2_r : slotId_r;

  //////////////////////////////////////////////////////////////////////////
  // Pins from off-board pass two flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slotSync1_r <= 5'h00;
      slotSync2_r <= 5'h00;
      rotSync1_r  <= 16'h0000;
      rotSync2_r  <= 16'h0000;
    end else begin
      slotSync1_r <= backplaneSlot;
      slotSync2_r <= slotSync1_r;
      rotSync1_r  <= rotaryBase;
      rotSync2_r  <= rotSync1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Writable configuration, one block per register
  // control register write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= vrcr_pkg::CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_r <= regWdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      monDac_r <= vrcr_pkg::MON_DAC_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_MON_DAC)) begin
      monDac_r <= regWdata[11:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      monFunc_r <= vrcr_pkg::MON_FUNC_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_MON_FUNC)) begin
      monFunc_r <= regWdata[2:0];
    end
  end

  // writable slot id
  // Stored on both variants; backplane variant never reads it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slotId_r <= vrcr_pkg::SLOT_ID_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_SLOT_ID)) begin
      slotId_r <= regWdata[4:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mcast_r <= vrcr_pkg::MCAST_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_MCAST)) begin
      mcast_r <= regWdata[9:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      base_relocation_enable_r <= vrcr_pkg::BASE_RELOCATION_ENABLE_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_BASE_RELOCATION_ENABLE)) begin
      base_relocation_enable_r <= regWdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vector_r <= vrcr_pkg::VECTOR_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_VECTOR)) begin
      vector_r <= regWdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      thresh_r <= vrcr_pkg::THRESH_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_EVT_THRESH)) begin
      thresh_r <= regWdata[9:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blt_r <= vrcr_pkg::BLT_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_BLT_EVENTS)) begin
      blt_r <= regWdata[7:0];
    end
  end

  // Scratch word for bus tests
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scratch_r <= vrcr_pkg::SCRATCH_RST;
    end else if (regWrite && (regAddr == vrcr_pkg::OFS_SCRATCH)) begin
      scratch_r <= regWdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky flag, new error beats read clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      berrFlag_r <= 1'b0;
    end else if (busErrorEvent) begin
      berrFlag_r <= 1'b1;
    end else if (regRead && (regAddr == vrcr_pkg::OFS_STATUS)) begin
      berrFlag_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus interrupt request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vmeArmed_r <= 1'b1;
      vmePend_r  <= 1'b0;
    end else if (wrCtrl) begin
      vmeArmed_r <= levelNxt != 3'h0;
      vmePend_r  <= (levelNxt != 3'h0) && vmePend_r;
    end else if (intAck && vmePend_r && ctrl_r[vrcr_pkg::CTRL_RELEASE_BIT]
                 && (intAckLevel == ctrl_r[2:0])) begin
      vmePend_r  <= 1'b0;
      vmeArmed_r <= 1'b0;
    end else if (overThresh && vmeArmed_r && (ctrl_r[2:0] != 3'h0)) begin
      vmePend_r <= 1'b1;
    end
  end

  // optical link releases on access only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      optPend_r <= 1'b0;
    end else if (wrCtrl && !regWdata[vrcr_pkg::CTRL_OPTIRQ_BIT]) begin
      optPend_r <= 1'b0;
    end else if (wrCtrl && (levelNxt == 3'h0)) begin
      optPend_r <= 1'b0;
    end else if (overThresh && ctrl_r[vrcr_pkg::CTRL_OPTIRQ_BIT]
                 && (ctrl_r[2:0] != 3'h0)) begin
      // Level zero disables, else a clear would refire at once
      optPend_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (regAddr)
      vrcr_pkg::OFS_MON_DAC:    rdata_nxt = {20'h00000, monDac_r};
      vrcr_pkg::OFS_BOARD_INFO: rdata_nxt = {16'h0000, MEM_MBYTES,
                                             BOARD_TYPE};
      vrcr_pkg::OFS_MON_FUNC:   rdata_nxt = {29'h00000000, monFunc_r};
      vrcr_pkg::OFS_EVT_WORDS:  rdata_nxt = nextEventWords;
      vrcr_pkg::OFS_CTRL:       rdata_nxt = {24'h000000, ctrl_r};
      vrcr_pkg::OFS_STATUS:     rdata_nxt = {29'h00000000, berrFlag_r,
                                             bufferFull, eventReady};
      vrcr_pkg::OFS_SLOT_ID:    rdata_nxt = {27'h0000000, slotSrc};
      vrcr_pkg::OFS_MCAST:      rdata_nxt = {22'h000000, mcast_r};
      vrcr_pkg::OFS_BASE_RELOCATION_ENABLE:      rdata_nxt = {16'h0000, base_relocation_enable_r};
      vrcr_pkg::OFS_VECTOR:     rdata_nxt = vector_r;
      vrcr_pkg::OFS_EVT_THRESH: rdata_nxt = {22'h000000, thresh_r};
      vrcr_pkg::OFS_BLT_EVENTS: rdata_nxt = {24'h000000, blt_r};
      vrcr_pkg::OFS_SCRATCH:    rdata_nxt = scratch_r;
      default:                  rdata_nxt = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
    end else begin
      regRdata <= regRead ? rdata_nxt : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // vector on acknowledge
  // Zero outside acknowledge keeps the data lines quiet
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      intAckData <= 32'h00000000;
    end else begin
      intAckData <= intAck ? vector_r : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt request outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vmeIrqLevel <= 3'h0;
      vmeIrq      <= 1'b0;
      opticalIrq  <= 1'b0;
    end else begin
      vmeIrqLevel <= ctrl_r[2:0];
      vmeIrq      <= vmePend_r;
      opticalIrq  <= optPend_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // base source select
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      baseAddrHigh <= 16'h0000;
    end else begin
      baseAddrHigh <= ctrl_r[vrcr_pkg::CTRL_BASE_RELOCATION_ENABLE_BIT] ? base_relocation_enable_r
                                                       : rotSync2_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Readout mode bits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alignEnable    <= 1'b0;
      busErrorEnable <= 1'b0;
    end else begin
      alignEnable    <= ctrl_r[vrcr_pkg::CTRL_ALIGN_BIT];
      busErrorEnable <= ctrl_r[vrcr_pkg::CTRL_BERR_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration copies, one cycle behind the registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      monitorLevel    <= vrcr_pkg::MON_DAC_RST;
      monitorFunction <= vrcr_pkg::MON_FUNC_RST;
      headerBoardId   <= vrcr_pkg::SLOT_ID_RST;
      chainRole       <= 2'h0;
      multicastHigh   <= 8'h00;
      bltEvents       <= vrcr_pkg::BLT_RST;
    end else begin
      monitorLevel    <= monDac_r;
      monitorFunction <= monFunc_r;
      headerBoardId   <= slotSrc;
      chainRole       <= mcast_r[9:8];
      multicastHigh   <= mcast_r[7:0];
      bltEvents       <= blt_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write strobes, one cycle each
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      memoryClear <= 1'b0;
      softReset   <= 1'b0;
    end else begin
      memoryClear <= regWrite && (regAddr == vrcr_pkg::OFS_SW_CLEAR);
      softReset   <= regWrite && (regAddr == vrcr_pkg::OFS_SW_RESET);
    end
  end

endmodule // vrcr_regs

// ===== vrcr_pkg.sv
// Package: register map, field positions and reset values
package vrcr_pkg;
  localparam logic [15:0] OFS_MON_DAC      = 16'h8138;
  localparam logic [15:0] OFS_BOARD_INFO   = 16'h8140;
  localparam logic [15:0] OFS_MON_FUNC     = 16'h8144;
  localparam logic [15:0] OFS_EVT_WORDS    = 16'h814c;
  localparam logic [15:0] OFS_CTRL         = 16'hef00;
  localparam logic [15:0] OFS_STATUS       = 16'hef04;
  localparam logic [15:0] OFS_SLOT_ID      = 16'hef08;
  localparam logic [15:0] OFS_MCAST        = 16'hef0c;
  localparam logic [15:0] OFS_BASE_RELOCATION_ENABLE        = 16'hef10;
  localparam logic [15:0] OFS_VECTOR       = 16'hef14;
  localparam logic [15:0] OFS_EVT_THRESH   = 16'hef18;
  localparam logic [15:0] OFS_BLT_EVENTS   = 16'hef1c;
  localparam logic [15:0] OFS_SCRATCH      = 16'hef20;
  localparam logic [15:0] OFS_SW_RESET     = 16'hef24;
  localparam logic [15:0] OFS_SW_CLEAR     = 16'hef28;
  // Control field positions
  localparam int CTRL_RELEASE_BIT = 7;
  localparam int CTRL_BASE_RELOCATION_ENABLE_BIT   = 6;
  localparam int CTRL_ALIGN_BIT   = 5;
  localparam int CTRL_BERR_BIT    = 4;
  localparam int CTRL_OPTIRQ_BIT  = 3;
  // Status field positions
  localparam int STAT_BERR_BIT  = 2;
  localparam int STAT_FULL_BIT  = 1;
  localparam int STAT_READY_BIT = 0;
  // Reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [11:0] MON_DAC_RST  = 12'h000;
  localparam logic [2:0]  MON_FUNC_RST = 3'h0;
  localparam logic [4:0]  SLOT_ID_RST  = 5'h00;
  localparam logic [9:0]  MCAST_RST    = 10'h000;
  localparam logic [15:0] BASE_RELOCATION_ENABLE_RST    = 16'h0000;
  localparam logic [31:0] VECTOR_RST   = 32'h00000000;
  localparam logic [9:0]  THRESH_RST   = 10'h000;
  localparam logic [7:0]  BLT_RST      = 8'h00;
  localparam logic [31:0] SCRATCH_RST  = 32'h00000000;
  // Monitor function codes
  typedef enum logic [2:0] {
    MON_MAJORITY = 3'h0,
    MON_SAWTOOTH = 3'h1,
    MON_RESERVED = 3'h2,
    MON_OCCUPANCY = 3'h3,
    MON_VOLTAGE  = 3'h4
  } vrcr_mon_t;
  // Daisy-chain roles
  typedef enum logic [1:0] {
    CHAIN_OFF   = 2'h0,
    CHAIN_LAST  = 2'h1,
    CHAIN_FIRST = 2'h2,
    CHAIN_MID   = 2'h3
  } vrcr_chain_t;
endpackage

// ===== vrcr_host_model.sv
// Backplane master model driving the register bank strobes
`timescale 1ns/100ps
module vrcr_host_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] regRdata,
  input  wire logic [31:0] intAckData,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regAddr,
  output logic      [31:0] regWdata,
  output logic             intAck,
  output logic      [2:0]  intAckLevel
);
  initial {regWrite, regRead, intAck, regAddr, regWdata, intAckLevel} = '0;
  // Control writes release
  // Released lines show the inverse so a stale value never matches
  task automatic wr(input logic [15:0] a, input logic [31:0] w);
    @(negedge clk_sys);
    {regWrite, regAddr, regWdata} = {1'b1, a, w};
    @(negedge clk_sys);
    {regWrite, regAddr, regWdata} = {1'b0, ~a, ~w};
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] r);
    @(negedge clk_sys);
    {regRead, regAddr} = {1'b1, a};
    @(negedge clk_sys);
    r = regRdata;
    {regRead, regAddr} = {1'b0, ~a};
  endtask
  task automatic ack(input logic [2:0] l, output logic [31:0] r);
    @(negedge clk_sys);
    {intAck, intAckLevel} = {1'b1, l};
    @(negedge clk_sys);
    r = intAckData;
    {intAck, intAckLevel} = {1'b0, ~l};
  endtask
endmodule // vrcr_host_model

// ===== vrcr_regs_sva.sv
// Port checker for the register bank
`timescale 1ns/100ps
module vrcr_regs_sva (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic        intAck,
  input wire logic [2:0]  intAckLevel,
  input wire logic [31:0] intAckData,
  input wire logic [2:0]  vmeIrqLevel,
  input wire logic        vmeIrq,
  input wire logic        busErrorEvent,
  input wire logic        alignEnable,
  input wire logic        busErrorEnable,
  input wire logic        memoryClear,
  input wire logic        softReset
);
  logic [7:0] ctrl_r;
  logic       ctlWr;
  logic       stRd;
  assign ctlWr = regWrite && regAddr == vrcr_pkg::OFS_CTRL;
  assign stRd  = regRead && regAddr == vrcr_pkg::OFS_STATUS &&
                 !busErrorEvent;
  // Control mirror; soft reset ignored, bench fires it at defaults only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) ctrl_r <= 8'h00;
    else if (ctlWr) ctrl_r <= regWdata[7:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  AST_ACK_DROP: assert property (ctrl_r[7] && intAck && vmeIrq &&
    intAckLevel == vmeIrqLevel |-> ##[1:2] !vmeIrq) else $error("ack kept");
  AST_LVL0_DROP: assert property (ctlWr && regWdata[2:0] == 3'h0
    |-> ##[1:2] !vmeIrq) else $error("level zero kept request");
  AST_ALIGN: assert property (alignEnable == $past(ctrl_r[5]))
    else $error("alignment enable wrong");
  AST_BERR_EN: assert property (busErrorEnable == $past(ctrl_r[4]))
    else $error("bus error enable wrong");
  AST_VEC_IDLE: assert property (!intAck |=> intAckData == 32'h0)
    else $error("vector outside acknowledge");
  AST_CLR: assert property (memoryClear ==
    $past(regWrite && regAddr == vrcr_pkg::OFS_SW_CLEAR))
    else $error("clear pulse wrong");
  AST_SWRST: assert property (softReset ==
    $past(regWrite && regAddr == vrcr_pkg::OFS_SW_RESET))
    else $error("reset pulse wrong");
  AST_STAT_CLR: assert property (stRd ##1 !busErrorEvent ##1 stRd
    |=> !regRdata[2]) else $error("bus error flag not cleared");
endmodule // vrcr_regs_sva
bind vrcr_regs vrcr_regs_sva u_sva (.clk_sys, .rst_n, .regWrite, .regRead,
  .regAddr, .regWdata, .regRdata, .intAck, .intAckLevel, .intAckData,
  .vmeIrqLevel, .vmeIrq, .busErrorEvent, .alignEnable, .busErrorEnable,
  .memoryClear, .softReset);

// ===== vrcr_regs_test.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
module vrcr_regs_test;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        bufferFull = 1'b0, eventReady = 1'b0, busErrorEvent = 1'b0;
  logic        regWrite, regRead, intAck, vmeIrq, opticalIrq, alignEnable;
  logic        busErrorEnable, memoryClear, softReset;
  logic [1:0]  chainRole;
  logic [2:0]  intAckLevel, vmeIrqLevel, monitorFunction;
  logic [4:0]  backplaneSlot = 5'h15, headerBoardId;
  logic [7:0]  multicastHigh, bltEvents;
  logic [9:0]  storedEvents = 10'h000;
  logic [11:0] monitorLevel;
  logic [15:0] regAddr, baseAddrHigh, rotaryBase = 16'h0000;
  logic [31:0] regWdata, regRdata, intAckData, d, v, nextEventWords = 32'h0;
  logic [31:0] rdExt;
  logic [4:0]  slotExt;
  int          mismatches = 0, checks_done = 0, seed = 32'haa38af2b;
  logic [15:0] rwOfs [9] = '{vrcr_pkg::OFS_MON_DAC, vrcr_pkg::OFS_MON_FUNC,
    vrcr_pkg::OFS_SLOT_ID, vrcr_pkg::OFS_MCAST, vrcr_pkg::OFS_BASE_RELOCATION_ENABLE,
    vrcr_pkg::OFS_VECTOR, vrcr_pkg::OFS_EVT_THRESH, vrcr_pkg::OFS_BLT_EVENTS,
    vrcr_pkg::OFS_SCRATCH};
  logic [31:0] rwMask [9] = '{32'hfff, 32'h7, 32'h1f, 32'h3ff, 32'hffff,
    32'hffffffff, 32'h3ff, 32'hff, 32'hffffffff};
  always #12.5 clk_sys = ~clk_sys;
  vrcr_regs dut (.clk_sys, .rst_n, .regWrite, .regRead, .regAddr, .regWdata,
    .regRdata, .intAck, .intAckLevel, .intAckData, .vmeIrqLevel, .vmeIrq,
    .opticalIrq, .nextEventWords, .storedEvents, .bufferFull, .eventReady,
    .busErrorEvent, .backplaneSlot, .rotaryBase, .baseAddrHigh, .alignEnable,
    .busErrorEnable, .monitorLevel, .monitorFunction, .headerBoardId,
    .chainRole, .multicastHigh, .bltEvents, .memoryClear, .softReset);
  vrcr_host_model host (.clk_sys, .regRdata, .intAckData, .regWrite,
    .regRead, .regAddr, .regWdata, .intAck, .intAckLevel);
  vrcr_regs #(.EXT_BACKPLANE(1'b1)) dutExt (.clk_sys, .rst_n, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata(rdExt), .intAck, .intAckLevel,
    .intAckData(), .vmeIrqLevel(), .vmeIrq(), .opticalIrq(), .nextEventWords,
    .storedEvents, .bufferFull, .eventReady, .busErrorEvent, .backplaneSlot,
    .rotaryBase, .baseAddrHigh(), .alignEnable(), .busErrorEnable(),
    .monitorLevel(), .monitorFunction(), .headerBoardId(slotExt),
    .chainRole(), .multicastHigh(), .bltEvents(), .memoryClear(),
    .softReset());
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic [31:0] stat_exp(logic b, logic f, logic r);
    return {29'h0, b, f, r};
  endfunction
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard, far beyond the real run
  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    idle(3);
    rst_n = 1'b1;
    // Pulses fired while control is at defaults
    host.wr(vrcr_pkg::OFS_SW_CLEAR, $random(seed));
    host.wr(vrcr_pkg::OFS_SW_RESET, $random(seed));
    foreach (rwOfs[i]) begin
      host.rd(rwOfs[i], d);
      check(d, 32'h0);
      v = $random(seed);
      host.wr(rwOfs[i], v);
      host.rd(rwOfs[i], d);
      check(d, v & rwMask[i]);
    end
    // Backplane variant reads the slot pins
    backplaneSlot = 5'($random(seed));
    idle(3);
    host.rd(vrcr_pkg::OFS_SLOT_ID, d);
    check(rdExt, 32'(backplaneSlot));
    check(32'(slotExt), 32'(backplaneSlot));
    $display("test readback done");
    for (int c = 0; c < 5; c++) begin
      v = $random(seed);
      v[9:8] = c[1:0];
      host.wr(vrcr_pkg::OFS_MON_FUNC, 32'(c));
      host.wr(vrcr_pkg::OFS_MCAST, v);
      host.wr(vrcr_pkg::OFS_MON_DAC, v);
      host.wr(vrcr_pkg::OFS_BLT_EVENTS, v);
      host.wr(vrcr_pkg::OFS_SLOT_ID, v);
      idle(1);
      d = 32'({monitorFunction, chainRole, multicastHigh});
      check(d, 32'({c[2:0], v[9:0]}));
      d = 32'({monitorLevel, bltEvents, headerBoardId});
      check(d, 32'({v[11:0], v[7:0], v[4:0]}));
    end
    nextEventWords = $random(seed);
    host.wr(vrcr_pkg::OFS_EVT_WORDS, ~nextEventWords);
    host.wr(vrcr_pkg::OFS_BOARD_INFO, $random(seed));
    host.rd(vrcr_pkg::OFS_EVT_WORDS, d);
    check(d, nextEventWords);
    host.rd(vrcr_pkg::OFS_BOARD_INFO, d);
    check(d, 32'h0100);
    host.rd(16'hef40, d);
    check(d, 32'h0);
    rotaryBase = 16'($random(seed));
    v = $random(seed);
    host.wr(vrcr_pkg::OFS_BASE_RELOCATION_ENABLE, v);
    host.wr(vrcr_pkg::OFS_CTRL, 32'h30);
    idle(4);
    check(32'(baseAddrHigh), 32'(rotaryBase));
    check(32'({alignEnable, busErrorEnable}), 32'h3);
    host.wr(vrcr_pkg::OFS_CTRL, 32'h40);
    idle(1);
    check(32'(baseAddrHigh), 32'(v[15:0]));
    {bufferFull, eventReady} = 2'($random(seed));
    busErrorEvent = 1'b1;
    idle(1);
    busErrorEvent = 1'b0;
    host.rd(vrcr_pkg::OFS_STATUS, d);
    check(d, stat_exp(1'b1, bufferFull, eventReady));
    host.rd(vrcr_pkg::OFS_STATUS, d);
    check(d, stat_exp(1'b0, bufferFull, eventReady));
    $display("test status done");
    v = $random(seed);
    host.wr(vrcr_pkg::OFS_VECTOR, v);
    host.wr(vrcr_pkg::OFS_EVT_THRESH, 32'h5);
    host.wr(vrcr_pkg::OFS_CTRL, 32'h0b);
    storedEvents = 10'h005;
    idle(4);
    check(32'({vmeIrq, opticalIrq}), 32'h0);
    storedEvents = 10'h006;
    idle(3);
    check(32'({vmeIrq, opticalIrq, vmeIrqLevel}), 32'h1b);
    host.ack(3'h3, d);
    check(d, v);
    idle(3);
    check(32'({vmeIrq, opticalIrq}), 32'h3);
    host.wr(vrcr_pkg::OFS_CTRL, 32'h08);
    idle(3);
    check(32'({vmeIrq, opticalIrq}), 32'h0);
    host.wr(vrcr_pkg::OFS_CTRL, 32'h8b);
    idle(3);
    check(32'({vmeIrq, opticalIrq}), 32'h3);
    host.ack(3'h3, d);
    idle(3);
    check(32'({vmeIrq, opticalIrq}), 32'h1);
    host.wr(vrcr_pkg::OFS_CTRL, 32'h8b);
    idle(3);
    check(32'(vmeIrq), 32'h1);
    $display("test interrupt done");
    print_verdict();
  end
endmodule // vrcr_regs_test
